// [dv/wwdt_core_tb_top.sv]
// Self-checking bench for the windowed watchdog core
`timescale 1ns/1ps
`include "wwdt_defines.svh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nFail++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module wwdt_core_tb_top import wwdt_pkg::*; ;
    // ==========================================
    // Signals
    localparam int SDIV = 4;
    localparam int PSC = 4;
    localparam int STEP = SDIV * PSC;
    logic clk, benchRst, rst, wdReset, honor;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic debugState, idleState, faultIrq;
    wwdt_fault_type faultReq;
    int nFail, nChecks;
    logic [7:0] rowAddr [4] = '{`WWDT_OFS_MR, `WWDT_OFS_SR, `WWDT_OFS_CR, 8'h0C};
    logic [31:0] rowData [4] = '{`WWDT_MODE_RESET, `WWDT_SR_RESET, 32'h0000_0000, 32'h0000_0000};
    logic [1:0] rowResp [4] = '{`WWDT_RESP_OKAY, `WWDT_RESP_OKAY, `WWDT_RESP_OKAY, `WWDT_RESP_SLVERR};
    logic [31:0] haltMode [3] = '{32'h0FFF_9004, 32'h1FFF_1004, 32'h2FFF_1004};
    assign rst = benchRst | wdReset;

    wwdt_core #(.ADDR_W(8), .SLOW_DIV(SDIV), .PRESCALE(PSC)) u_wwdt_core (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .debugState(debugState), .idleState(idleState), .faultIrq(faultIrq), .faultReq(faultReq));
    wwdt_rstc_model u_wwdt_rstc_model (.clk(clk), .benchRst(benchRst), .honor(honor), .faultReq(faultReq),
        .wdReset(wdReset));

    // ==========================================
    // Clock, start values, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {benchRst, honor, awvalid, wvalid, bready, arvalid, rready, debugState, idleState} = 9'h100;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    end
    initial begin
        #80000;
        nFail++;
        completeRun();
    end

    // ==========================================
    // Bus and helper tasks
    task automatic completeRun();
        if (nFail == 0 && nChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic busWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        r = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        nFail++;
    endtask
    task automatic busRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        r = 2'h3;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        nFail++;
    endtask
    // Returns cycles until interrupt or fault, -1 if none within the limit
    task automatic waitEvt(input int lim, output int cyc);
        cyc = -1;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            if (faultIrq === 1'b1 || faultReq.fault === 1'b1) begin
                cyc = i;
                return;
            end
        end
    endtask
    task automatic doReset();
        @(posedge clk);
        benchRst <= 1'b1;
        repeat (2) @(posedge clk);
        benchRst <= 1'b0;
    endtask

    // ==========================================
    // Main sequence; no mode write ever follows a restart within the settle time
    initial begin
        int cyc;
        logic [31:0] d;
        logic [1:0] r;
        doReset();
        for (int i = 0; i < 4; i++) begin
            busRead(rowAddr[i], d, r);
            `CHK(d, rowData[i])
            `CHK(r, rowResp[i])
        end
        busWrite(8'h0C, 32'hFFFF_FFFF, r);
        `CHK(r, `WWDT_RESP_SLVERR)
        // Both state inputs high with halts off: counter must keep running
        debugState <= 1'b1;
        idleState <= 1'b1;
        busWrite(`WWDT_OFS_MR, 32'h0FFF_1008, r);
        waitEvt(400, cyc);
        `CHK(cyc inside {[9 * STEP - 8 : 9 * STEP + 8]}, 1'b1)
        `CHK(faultReq, 3'b000)
        busWrite(`WWDT_OFS_MR, 32'h0000_0000, r);
        busRead(`WWDT_OFS_MR, d, r);
        `CHK(d, 32'h0FFF_1008)
        busRead(`WWDT_OFS_SR, d, r);
        `CHK(d, 32'h0000_0001)
        `CHK(faultIrq, 1'b0)
        busRead(`WWDT_OFS_SR, d, r);
        `CHK(d, 32'h0000_0000)
        // Restart midway with the default-wide window reloads the count
        doReset();
        busWrite(`WWDT_OFS_MR, 32'h0FFF_1008, r);
        repeat (100) @(posedge clk);
        busWrite(`WWDT_OFS_CR, {`WWDT_KEY, 24'h000001}, r);
        waitEvt(400, cyc);
        `CHK(cyc inside {[9 * STEP - 8 : 9 * STEP + 8]}, 1'b1)
        busRead(`WWDT_OFS_SR, d, r);
        `CHK(d, 32'h0000_0001)
        // Narrow window: wrong key is dropped, keyed restart above delta errors
        doReset();
        busWrite(`WWDT_OFS_MR, 32'h0002_1008, r);
        busWrite(`WWDT_OFS_CR, 32'h5A00_0001, r);
        busRead(`WWDT_OFS_SR, d, r);
        `CHK(d, 32'h0000_0000)
        busWrite(`WWDT_OFS_CR, {`WWDT_KEY, 24'h000001}, r);
        busRead(`WWDT_OFS_SR, d, r);
        `CHK(d, 32'h0000_0002)
        // Fault routing, held level, and reset by the controller
        for (int p = 0; p < 2; p++) begin
            doReset();
            honor <= p[0];
            busWrite(`WWDT_OFS_MR, 32'h0FFF_2004 | (32'h0000_4000 * p), r);
            waitEvt(400, cyc);
            `CHK(faultReq, {1'b1, ~p[0], p[0]})
            repeat (20) @(posedge clk);
            `CHK(faultReq.fault, !p[0])
            busRead(p ? `WWDT_OFS_MR : `WWDT_OFS_SR, d, r);
            `CHK(d, p ? `WWDT_MODE_RESET : 32'h0000_0001)
            `CHK(faultReq, 3'b000)
        end
        // Disable never fires; debug and idle halts resume once released
        for (int k = 0; k < 3; k++) begin
            doReset();
            debugState <= (k == 1);
            idleState <= (k == 2);
            busWrite(`WWDT_OFS_MR, haltMode[k], r);
            waitEvt(300, cyc);
            `CHK(cyc, -1)
            debugState <= 1'b0;
            idleState <= 1'b0;
            waitEvt(200, cyc);
            `CHK(cyc >= 0, k > 0)
        end
        completeRun();
    end
endmodule

// [dv/wwdt_rstc_model.sv]
// Reset controller stand-in that answers watchdog fault requests
`timescale 1ns/1ps

module wwdt_rstc_model import wwdt_pkg::*; (
    input wire logic clk,
    input wire logic benchRst,
    input wire logic honor,
    input wire wwdt_fault_type faultReq,
    output logic wdReset
);
    // ==========================================
    // Reset pulse
    logic [1:0] pulseCnt_q;
    logic [1:0] pulseCnt_d;
    // Fault already carries the reset enable, so no gating here; honor lets a scenario watch the held level
    assign pulseCnt_d = (pulseCnt_q != 2'h0) ? pulseCnt_q - 2'h1 : ((honor && faultReq.fault) ? 2'h2 : 2'h0);
    always_ff @(posedge clk) begin
        if (benchRst)
            pulseCnt_q <= 2'h0;
        else
            pulseCnt_q <= pulseCnt_d;
    end
    assign wdReset = pulseCnt_q != 2'h0;
endmodule

// [verilog/wwdt_core.sv]
// Windowed watchdog timer with key-protected restart and an AXI4-Lite register slave
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module wwdt_core import wwdt_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int SLOW_DIV = `WWDT_SLOW_DIV,
    parameter int PRESCALE = `WWDT_PRESCALE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic debugState,
    input wire logic idleState,
    output logic faultIrq,
    output wwdt_fault_type faultReq
);

    localparam int PRE_W = $clog2(PRESCALE);
    localparam int SLOW_W = $clog2(SLOW_DIV + 1);

    // ==========================================
    // Elaboration checks
    generate
        if (SLOW_DIV < 1 || PRESCALE < 2 || (PRESCALE & (PRESCALE - 1)) != 0) begin : g_bad
            $error("wwdt_core: SLOW_DIV must be >= 1, PRESCALE a power of two >= 2");
        end
        if (ADDR_W < 4) begin : g_bad_addr
            $error("wwdt_core: ADDR_W too small for the register map");
        end
    endgenerate

    // ==========================================
    // State
    wwdt_mode_type mode_q, mode_d, mrNew;
    logic modeLocked_q;
    logic [11:0] cnt_q, cnt_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [SLOW_W-1:0] slow_q, slow_d;
    logic unf_q, unf_d, err_q, err_d;
    wwdt_fault_type fault_q, fault_d;
    logic irq_q;
    logic awReady_q, wReady_q, bValid_q, awFull_q, wFull_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic [1:0] bResp_q;
    wwdt_rd_state_type rdState_q, rdState_d;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;

    // ==========================================
    // Write channel handshake
    wire awTake = awvalid && awReady_q;
    wire wTake = wvalid && wReady_q;
    wire doWrite = awFull_q && wFull_q;
    wire awFull_d = (awFull_q || awTake) && !doWrite;
    wire wFull_d = (wFull_q || wTake) && !doWrite;
    wire bValid_d = doWrite || (bValid_q && !bready);
    // Ready drops while a response is pending: one write at a time
    wire awReady_d = !awFull_d && !bValid_d;
    wire wReady_d = !wFull_d && !bValid_d;

    wire wrCr = awAddr_q == ADDR_W'(`WWDT_OFS_CR);
    wire wrMr = awAddr_q == ADDR_W'(`WWDT_OFS_MR);
    wire wrSr = awAddr_q == ADDR_W'(`WWDT_OFS_SR);
    wire [1:0] wrResp = (wrCr || wrMr || wrSr) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;

    always_ff @(posedge clk) begin
        if (rst) begin
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            awFull_q <= 1'b0;
            wFull_q <= 1'b0;
            bValid_q <= 1'b0;
        end else begin
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            awFull_q <= awFull_d;
            wFull_q <= wFull_d;
            bValid_q <= bValid_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            awAddr_q <= '0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bResp_q <= `WWDT_RESP_OKAY;
        end else begin
            if (awTake) awAddr_q <= awaddr;
            if (wTake) wData_q <= wdata;
            if (wTake) wStrb_q <= wstrb;
            if (doWrite) bResp_q <= wrResp;
        end
    end

    // ==========================================
    // Register write effects
    // Key and restart bit must both be in the written lanes
    wire keyOk = wStrb_q[3] && wStrb_q[0] && wData_q[31:`WWDT_KEY_LSB] == `WWDT_KEY;
    wire crRestart = doWrite && wrCr && keyOk && wData_q[`WWDT_RSTT_BIT];
    wire winErr = cnt_q > mode_q.restartWindowDelta;
    wire restartOk = crRestart && !winErr;
    wire restartErr = crRestart && winErr;
    wire mrWrite = doWrite && wrMr && !modeLocked_q;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign mrNew[8*gi +: 8] = wStrb_q[gi] ? wData_q[8*gi +: 8] : mode_q[8*gi +: 8];
        end
    endgenerate

    assign mode_d = mrWrite ? mrNew : mode_q;
    wire reload = restartOk || mrWrite;
    wire [11:0] loadVal = mrWrite ? mrNew.counterLoadValue : mode_q.counterLoadValue;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= `WWDT_MODE_RESET;
            modeLocked_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (doWrite && wrMr) modeLocked_q <= 1'b1;
        end
    end

    // ==========================================
    // Prescaler and down counter
    wire halted = (debugState && mode_q.debugHalt) || (idleState && mode_q.idleHalt);
    wire running = !mode_q.timerDisable && !halted;
    // Slow clock is derived here; it is never reset by a restart, only the 128 stage is
    wire slowTick = slow_q == SLOW_W'(SLOW_DIV - 1);
    assign slow_d = slowTick ? '0 : slow_q + SLOW_W'(1);
    wire preTick = running && slowTick && pre_q == PRE_W'(PRESCALE - 1);
    wire unfEvent = preTick && !reload && cnt_q == 12'h000;

    always_comb begin
        pre_d = pre_q;
        if (reload) pre_d = '0;
        else if (running && slowTick) pre_d = pre_q + PRE_W'(1);
    end

    always_comb begin
        cnt_d = cnt_q;
        if (reload) cnt_d = loadVal;
        else if (unfEvent) cnt_d = mode_q.counterLoadValue;
        else if (preTick) cnt_d = cnt_q - 12'h001;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            slow_q <= '0;
            pre_q <= '0;
            cnt_q <= `WWDT_CNT_RESET;
        end else begin
            slow_q <= slow_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================
    // Read channel
    wire arTake = arvalid && rdState_q[0];
    wire rdCr = araddr == ADDR_W'(`WWDT_OFS_CR);
    wire rdMr = araddr == ADDR_W'(`WWDT_OFS_MR);
    wire rdSr = araddr == ADDR_W'(`WWDT_OFS_SR);
    wire srRead = arTake && rdSr;
    wire [31:0] srValue = {30'h0000_0000, err_q, unf_q};
    wire [31:0] rdMux = rdMr ? mode_q : (rdSr ? srValue : 32'h0000_0000);
    wire [1:0] rdResp = (rdCr || rdMr || rdSr) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;

    always_comb begin
        case (rdState_q)
            RD_IDLE: rdState_d = arTake ? RD_DATA : RD_IDLE;
            RD_DATA: rdState_d = rready ? RD_IDLE : RD_DATA;
            default: rdState_d = RD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdState_q <= RD_IDLE;
            rData_q <= 32'h0000_0000;
            rResp_q <= `WWDT_RESP_OKAY;
        end else begin
            rdState_q <= rdState_d;
            if (arTake) rData_q <= rdMux;
            if (arTake) rResp_q <= rdResp;
        end
    end

    // ==========================================
    // Sticky flags, fault and interrupt
    // An event in the clearing cycle survives the read
    assign unf_d = unfEvent || (unf_q && !srRead);
    assign err_d = restartErr || (err_q && !srRead);
    wire faultEvent = (unfEvent || restartErr) && mode_q.faultResetEnable;
    assign fault_d.fault = faultEvent || (fault_q.fault && !srRead);
    assign fault_d.allResets = fault_d.fault && !mode_d.processorResetOnly;
    assign fault_d.procOnly = fault_d.fault && mode_d.processorResetOnly;

    always_ff @(posedge clk) begin
        if (rst) begin
            unf_q <= 1'b0;
            err_q <= 1'b0;
            fault_q <= '0;
            irq_q <= 1'b0;
        end else begin
            unf_q <= unf_d;
            err_q <= err_d;
            fault_q <= fault_d;
            irq_q <= (unf_d || err_d) && mode_d.faultInterruptEnable;
        end
    end

    // ==========================================
    // Outputs
    assign awready = awReady_q;
    assign wready = wReady_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign arready = rdState_q[0];
    assign rvalid = rdState_q[1];
    assign rdata = rData_q;
    assign rresp = rResp_q;
    assign faultIrq = irq_q;
    assign faultReq = fault_q;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seqGoodRestart;
        crRestart && !winErr;
    endsequence

    sequence seqReloaded;
        cnt_q == mode_q.counterLoadValue && pre_q == '0;
    endsequence

    property pRestartReload;
        seqGoodRestart |=> seqReloaded;
    endproperty

    a_restart_reload: assert property (pRestartReload)
        else $error("keyed restart did not reload counter and prescaler");
    a_reset_default: assert property ($past(rst) |-> mode_q == `WWDT_MODE_RESET && cnt_q == 12'hFFF)
        else $error("reset defaults wrong");
    a_mode_once: assert property (modeLocked_q && doWrite && wrMr |=> $stable(mode_q))
        else $error("mode register changed after first write");
    a_mode_reload: assert property (mrWrite |=> seqReloaded)
        else $error("mode write did not reload counter");
    a_bad_key: assert property (doWrite && wrCr && !keyOk && !unfEvent |=> $stable(err_q) && $stable(pre_q) || running)
        else $error("write with wrong key had an effect");
    a_window_err: assert property (crRestart && winErr |=> err_q && $stable(cnt_q) || $past(preTick))
        else $error("restart outside window not flagged");
    a_unf_flag: assert property (unfEvent |=> unf_q && fault_q.fault == $past(mode_q.faultResetEnable))
        else $error("underflow not flagged");
    a_status_clear: assert property (srRead && !unfEvent && !restartErr |=> !unf_q && !err_q && !faultIrq && !faultReq.fault)
        else $error("status read did not clear flags");
    a_halt_stop: assert property (!running && !reload |=> $stable(cnt_q) && $stable(pre_q))
        else $error("counter moved while halted or disabled");
    a_irq_gate: assert property (!mode_q.faultInterruptEnable ##1 !mode_q.faultInterruptEnable |-> !faultIrq)
        else $error("interrupt without enable");
    a_reset_scope: assert property (faultReq.fault |-> faultReq.procOnly == mode_q.processorResetOnly && faultReq.allResets == !mode_q.processorResetOnly)
        else $error("reset scope does not match select bit");
    a_fault_hold: assert property (faultReq.fault && !srRead |=> faultReq.fault)
        else $error("fault level dropped without a status read");

    // ==========================================
    // Counting cadence, flags and fault gating
    // A step that is neither a reload nor an underflow takes exactly one off
    sequence seqStep;
        preTick && !reload && cnt_q != 12'h000;
    endsequence

    sequence seqOneLess;
        cnt_q == $past(cnt_q) - 12'h001;
    endsequence

    a_count_step: assert property (seqStep |=> seqOneLess)
        else $error("counter step was not a decrement by one");
    a_tick_gate: assert property (preTick |-> slowTick && running)
        else $error("counter step without slow tick or while stopped");
    a_unf_reload: assert property (unfEvent |=> cnt_q == mode_q.counterLoadValue)
        else $error("underflow did not reload the counter");
    a_wide_window: assert property (crRestart && mode_q.restartWindowDelta >= cnt_q |-> !restartErr)
        else $error("restart inside wide window flagged as error");
    a_reset_flags: assert property ($past(rst) |-> !unf_q && !err_q && !faultIrq && faultReq == '0)
        else $error("flags or fault survived a reset");
    a_disable_quiet: assert property (mode_q.timerDisable |-> !preTick && !unfEvent)
        else $error("disabled watchdog still counted");
    a_flags_sticky: assert property ((unf_q || err_q) && !srRead |=> unf_q || err_q)
        else $error("status flag dropped without a status read");
    a_irq_follow: assert property ((unf_q || err_q) && mode_q.faultInterruptEnable && !srRead && !mrWrite |=> faultIrq)
        else $error("enabled interrupt missing while a flag is set");
    a_fault_gate: assert property (!mode_q.faultResetEnable && !faultReq.fault |=> !faultReq.fault)
        else $error("fault raised with reset generation off");

endmodule

// [verilog/wwdt_defines.svh]
// Offsets, field positions, reset values and timing counts of the windowed watchdog
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// ==========================================
// Register offsets (byte addresses)
`define WWDT_OFS_CR 8'h00
`define WWDT_OFS_MR 8'h04
`define WWDT_OFS_SR 8'h08

// ==========================================
// Reset values and key
`define WWDT_MODE_RESET 32'h3FFF_2FFF
`define WWDT_SR_RESET 32'h0000_0000
`define WWDT_CNT_RESET 12'hFFF
`define WWDT_KEY 8'hA5

// ==========================================
// Field positions
`define WWDT_KEY_LSB 24
`define WWDT_RSTT_BIT 0
`define WWDT_UNF_BIT 0
`define WWDT_ERR_BIT 1

// ==========================================
// Timing
`define WWDT_CLK_HZ 250000000
`define WWDT_SLOW_CLK_HZ 32768
`define WWDT_SLOW_DIV (`WWDT_CLK_HZ / `WWDT_SLOW_CLK_HZ)
`define WWDT_PRESCALE 128

// ==========================================
// Bus answers
`define WWDT_RESP_OKAY 2'h0
`define WWDT_RESP_SLVERR 2'h2

`endif

// [verilog/wwdt_pkg.sv]
// Types shared by the windowed watchdog
package wwdt_pkg;

    // Mode register layout, bit 31 down to bit 0
    typedef struct packed {
        logic [1:0] spare;
        logic idleHalt;
        logic debugHalt;
        logic [11:0] restartWindowDelta;
        logic timerDisable;
        logic processorResetOnly;
        logic faultResetEnable;
        logic faultInterruptEnable;
        logic [11:0] counterLoadValue;
    } wwdt_mode_type;

    // Requests toward the reset controller
    typedef struct packed {
        logic fault;
        logic allResets;
        logic procOnly;
    } wwdt_fault_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } wwdt_rd_state_type;

endpackage
